// ### rssc_top.sv
// rssc_top.sv: pin states, soft reset, hard standby, frame sync and source select
// assumes: host register writes arrive as a decoded strobe from the serial slave
// How it works
// [RQ1] chip reset low forces the reset state
// [RQ2] every output pin is high impedance during reset; sensor reset stays driven low instead
// [RQ3] host holds reset 50 cycles, clock running 10 cycles after
// [RQ4] host runs clock 10 cycles before releasing reset
// [RQ5] register writes ignored until 100 cycles after reset release
// [RQ6] write to soft reset register starts a soft reset sequence
// [RQ7] sensor reset low in reset and default, high in standby states
// [RQ8] strap pins sampled once after reset, then released
// [RQ9] video outputs hi-z in reset, driven only when used otherwise
// [RQ10] host always drives sync, standby, test reset and pixel inputs
// [RQ11] standby high enters hard standby within two frames
// [RQ12] standby low leaves hard standby
// [RQ13] host runs clock 10 cycles before dropping standby
// [RQ14] frame sync pulse starts streaming
// [RQ15] frame sync pulse is copied to sensor trigger output; trigger_oe stays low in the default state, so the pin is not driven there
// [RQ16] single-shot mode emits one frame per trigger
// [RQ17] continuous mode streams frames after one trigger
// [RQ18] frame valid follows sync with fixed latency, aligning cameras
// [RQ19] source select 0x02 plus apply picks test pattern, 0x00 sensor
// [RQ20] test pattern replaces sensor pixels in the pipeline
// [RQ21] reset, standby and frame sync pass two flops first
`timescale 1ns/100ps
`include "rssc_cfg.svh"
module rssc_top (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        chip_reset_n,
    input  wire logic        standby_in,
    input  wire logic        frame_sync_in,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    output logic             reg_ack,
    input  wire logic        sensor_frame_valid,
    input  wire logic        sensor_line_valid,
    input  wire logic [11:0] sensor_pixel,
    input  wire logic [11:0] test_pixel,
    input  wire logic        test_frame_valid,
    input  wire logic        test_line_valid,
    input  wire logic        video_used,
    input  wire logic        trigger_used,
    input  wire logic [3:0]  strap_in,
    output logic      [3:0]  strap_out,
    output logic      [3:0]  strap_oe,
    output logic      [3:0]  strap_value,
    output logic             strap_valid,
    output logic      [11:0] pipe_pixel,
    output logic             pipe_frame_valid,
    output logic             pipe_line_valid,
    output logic             frame_valid_out,
    output logic             frame_valid_oe,
    output logic             sensor_reset_n_out,
    output logic             sensor_reset_oe,
    output logic             trigger_out,
    output logic             trigger_oe,
    output logic             soft_reset_active
);
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] FIRST_CMD = CNT_W'(`RSSC_FIRST_CMD_CYC);
    localparam logic [CNT_W-1:0] SOFT_LEN  = CNT_W'(`RSSC_SOFT_RST_CYC);
    localparam logic [1:0]       STBY_FR   = 2'(`RSSC_STBY_FRAMES);

    logic chip_reset_n_s;
    logic standby_s;
    logic fsync_s;
    logic fsync_prev_q;

    // [RQ21] input synchronisers
    rssc_sync2 #(.RST_VAL(1'b0)) u_sync_rst (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (chip_reset_n),
        .q       (chip_reset_n_s)
    );
    rssc_sync2 #(.RST_VAL(1'b0)) u_sync_stby (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (standby_in),
        .q       (standby_s)
    );
    rssc_sync2 #(.RST_VAL(1'b0)) u_sync_fs (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       (frame_sync_in),
        .q       (fsync_s)
    );

    logic [3:0] strap_s;

    // [RQ8] strap pins synced first
    // straps are pins too, so they pass two flops before capture
    for (genvar g = 0; g < 4; g++) begin : g_strap_sync
        rssc_sync2 #(.RST_VAL(1'b0)) u_sync_strap (
            .clk_sys (clk_sys),
            .rst     (rst),
            .d       (strap_in[g]),
            .q       (strap_s[g])
        );
    end

    // [RQ1] held reset while pin low
    wire in_reset = ~chip_reset_n_s;

    rssc_pkg::rssc_state_type state_q;
    rssc_pkg::rssc_state_type state_d;
    logic [CNT_W-1:0] wake_cnt_q;
    logic [CNT_W-1:0] soft_cnt_q;
    logic [7:0]       src_sel_q;
    logic [7:0]       src_live_q;
    logic             trig_cont_q;
    logic             strap_done_q;
    logic [3:0]       strap_q;
    logic [1:0]       stby_frames_q;
    logic             sensor_fv_prev_q;
    logic             single_armed_q;
    logic [7:0]       rdata_q;
    logic             ack_q;

    // [RQ5] link ready after wake delay
    wire link_ready = (wake_cnt_q == FIRST_CMD);
    wire wr_ok      = reg_wr & link_ready & ~in_reset;
    wire rd_ok      = reg_rd & link_ready & ~in_reset;
    wire wr_src     = wr_ok & (reg_addr == `RSSC_REG_SRC_SEL);
    wire wr_soft    = wr_ok & (reg_addr == `RSSC_REG_SOFT_RST);
    wire wr_apply   = wr_ok & (reg_addr == `RSSC_REG_CFG_APPLY);
    wire wr_mode    = wr_ok & (reg_addr == `RSSC_REG_TRIG_MODE);
    wire fsync_rise = fsync_s & ~fsync_prev_q;
    wire fv_fall    = sensor_fv_prev_q & ~sensor_frame_valid;
    wire stby_done  = (stby_frames_q == STBY_FR) | ~sensor_frame_valid;
    wire in_standby = (state_q == rssc_pkg::RSSC_ST_STANDBY);
    wire in_stream  = (state_q == rssc_pkg::RSSC_ST_STREAM);
    wire use_test   = (src_live_q == `RSSC_SRC_TEST);

    wire [7:0] status_word = {3'h0, state_q};
    wire [7:0] rd_mux =
        (reg_addr == `RSSC_REG_SRC_SEL)   ? src_sel_q :
        (reg_addr == `RSSC_REG_TRIG_MODE) ? {7'h00, trig_cont_q} :
        (reg_addr == `RSSC_REG_STATUS)    ? status_word : 8'h00;

    always_comb begin
        state_d = state_q;
        case (state_q)
            rssc_pkg::RSSC_ST_DEFAULT: begin
                // [RQ11] standby request
                if (standby_s)
                    state_d = rssc_pkg::RSSC_ST_STANDBY;
                // [RQ14] sync starts streaming
                else if (fsync_rise)
                    state_d = rssc_pkg::RSSC_ST_STREAM;
            end
            rssc_pkg::RSSC_ST_STREAM: begin
                // [RQ11] stop within two frames
                if (standby_s && stby_done)
                    state_d = rssc_pkg::RSSC_ST_STANDBY;
                // [RQ16] single shot ends after one frame
                else if (!trig_cont_q && fv_fall && !single_armed_q)
                    state_d = rssc_pkg::RSSC_ST_IDLE;
            end
            rssc_pkg::RSSC_ST_IDLE: begin
                if (standby_s)
                    state_d = rssc_pkg::RSSC_ST_STANDBY;
                else if (fsync_rise)
                    state_d = rssc_pkg::RSSC_ST_STREAM;
            end
            rssc_pkg::RSSC_ST_STANDBY: begin
                // [RQ12] leave on standby low
                if (!standby_s)
                    state_d = rssc_pkg::RSSC_ST_IDLE;
            end
            rssc_pkg::RSSC_ST_SOFTRST: begin
                if (soft_cnt_q == SOFT_LEN)
                    state_d = rssc_pkg::RSSC_ST_DEFAULT;
            end
            default: state_d = rssc_pkg::RSSC_ST_DEFAULT;
        endcase
        // [RQ6] soft reset overrides
        if (wr_soft)
            state_d = rssc_pkg::RSSC_ST_SOFTRST;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q          <= rssc_pkg::RSSC_ST_DEFAULT;
            wake_cnt_q       <= '0;
            soft_cnt_q       <= '0;
            fsync_prev_q     <= 1'b0;
            sensor_fv_prev_q <= 1'b0;
            stby_frames_q    <= 2'h0;
            single_armed_q   <= 1'b0;
        end else if (in_reset) begin
            state_q          <= rssc_pkg::RSSC_ST_DEFAULT;
            wake_cnt_q       <= '0;
            soft_cnt_q       <= '0;
            fsync_prev_q     <= 1'b0;
            sensor_fv_prev_q <= 1'b0;
            stby_frames_q    <= 2'h0;
            single_armed_q   <= 1'b0;
        end else begin
            state_q          <= state_d;
            wake_cnt_q       <= link_ready ? wake_cnt_q : wake_cnt_q + 1'b1;
            soft_cnt_q       <= (state_q == rssc_pkg::RSSC_ST_SOFTRST) ?
                                soft_cnt_q + 1'b1 : '0;
            fsync_prev_q     <= fsync_s;
            sensor_fv_prev_q <= sensor_frame_valid;
            // [RQ11] count frames ended while standby pending
            if (!standby_s || !in_stream)
                stby_frames_q <= 2'h0;
            else if (fv_fall && stby_frames_q != STBY_FR)
                stby_frames_q <= stby_frames_q + 1'b1;
            // [RQ16] trigger seen, its frame not yet started
            if (fsync_rise)
                single_armed_q <= 1'b1;
            else if (sensor_frame_valid)
                single_armed_q <= 1'b0;
        end
    end

    // [RQ19] shadow and apply source select
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            src_sel_q   <= `RSSC_SRC_RESET;
            src_live_q  <= `RSSC_SRC_RESET;
            trig_cont_q <= 1'b0;
        end else if (in_reset || state_q == rssc_pkg::RSSC_ST_SOFTRST) begin
            src_sel_q   <= `RSSC_SRC_RESET;
            src_live_q  <= `RSSC_SRC_RESET;
            trig_cont_q <= 1'b0;
        end else begin
            if (wr_src)
                src_sel_q <= reg_wdata;
            if (wr_apply)
                src_live_q <= src_sel_q;
            // [RQ17] continuous trigger mode bit
            if (wr_mode)
                trig_cont_q <= reg_wdata[0];
        end
    end

    // [RQ8] one strap capture after reset release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            strap_done_q <= 1'b0;
            strap_q      <= 4'h0;
        end else if (in_reset) begin
            strap_done_q <= 1'b0;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            strap_q      <= strap_s;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= 8'h00;
            ack_q   <= 1'b0;
        end else begin
            rdata_q <= rd_ok ? rd_mux : rdata_q;
            ack_q   <= wr_ok | rd_ok;
        end
    end

    // [RQ20] test pattern replaces sensor data
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pipe_pixel       <= 12'h000;
            pipe_frame_valid <= 1'b0;
            pipe_line_valid  <= 1'b0;
            frame_valid_out  <= 1'b0;
        end else begin
            pipe_pixel       <= use_test ? test_pixel : sensor_pixel;
            pipe_frame_valid <= use_test ? test_frame_valid : sensor_frame_valid;
            pipe_line_valid  <= use_test ? test_line_valid : sensor_line_valid;
            // [RQ18] fixed one-cycle latency keeps cameras aligned
            frame_valid_out  <= in_stream & (use_test ? test_frame_valid
                                                      : sensor_frame_valid);
        end
    end

    assign reg_rdata         = rdata_q;
    assign reg_ack           = ack_q;
    assign soft_reset_active = (state_q == rssc_pkg::RSSC_ST_SOFTRST);
    assign strap_value       = strap_q;
    assign strap_valid       = strap_done_q;
    // [RQ8] straps released after sampling
    assign strap_out         = 4'h0;
    assign strap_oe          = 4'h0;
    // [RQ7] sensor reset high only while in standby
    assign sensor_reset_n_out = ~in_reset & in_standby;
    // [RQ2] sensor reset driver stays on, even in reset
    assign sensor_reset_oe   = 1'b1;
    // [RQ9] video driven only when used
    assign frame_valid_oe    = ~in_reset & video_used &
                               (state_q != rssc_pkg::RSSC_ST_SOFTRST);
    // [RQ15] sync copied to trigger output, pin driven only outside the default state
    assign trigger_out       = fsync_s;
    assign trigger_oe        = ~in_reset & trigger_used &
                               (state_q != rssc_pkg::RSSC_ST_DEFAULT);
endmodule : rssc_top

// ### rssc_cfg.svh
// rssc_cfg.svh: offsets, codes and timing counts for the reset/standby/sync control block
// assumes: included by bare name from the top module and the testbench
`ifndef RSSC_CFG_SVH
`define RSSC_CFG_SVH
`define RSSC_REG_SRC_SEL     16'hc88f
`define RSSC_REG_SOFT_RST    16'hc800
`define RSSC_REG_CFG_APPLY   16'hc801
`define RSSC_REG_TRIG_MODE   16'hc802
`define RSSC_REG_STATUS      16'hc803
`define RSSC_SRC_SENSOR      8'h00
`define RSSC_SRC_TEST        8'h02
`define RSSC_SRC_RESET       8'h00
`define RSSC_FIRST_CMD_CYC   100
`define RSSC_SOFT_RST_CYC    16
`define RSSC_STBY_FRAMES     2
`define RSSC_CLK_MHZ         125
`endif

// ### rssc_pkg.sv
// rssc_pkg.sv: types for the reset/standby/sync control block
// assumes: cfg header holds all numbers but the state codes
package rssc_pkg;
    typedef enum logic [4:0] {
        RSSC_ST_DEFAULT  = 5'h01,
        RSSC_ST_STREAM   = 5'h02,
        RSSC_ST_IDLE     = 5'h04,
        RSSC_ST_STANDBY  = 5'h08,
        RSSC_ST_SOFTRST  = 5'h10
    } rssc_state_type;
endpackage : rssc_pkg

// ### rssc_sync2.sv
// rssc_sync2.sv: two-flop synchroniser for one level
// assumes: d comes from outside the clk_sys domain
`timescale 1ns/100ps
module rssc_sync2 #(
    parameter logic RST_VAL = 1'b0
) (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic d,
    output logic      q
);
    logic meta_q;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= RST_VAL;
            q      <= RST_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule : rssc_sync2

// ### rssc_top_assertions.sv
// rssc_top_assertions.sv: port-level checks for the reset/standby/sync block
// assumes: bound to rssc_top, one clock domain, rst async high
`timescale 1ns/100ps
module rssc_top_assertions (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic chip_reset_n,
    input wire logic standby_in,
    input wire logic frame_sync_in,
    input wire logic sensor_frame_valid,
    input wire logic video_used,
    input wire logic trigger_used,
    input wire logic frame_valid_oe,
    input wire logic sensor_reset_n_out,
    input wire logic sensor_reset_oe,
    input wire logic trigger_out,
    input wire logic trigger_oe,
    input wire logic soft_reset_active
);
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    // four samples allow for the two-flop input sync
    a_reset_hiz: assert property (
        !chip_reset_n [*4] |-> !frame_valid_oe && !trigger_oe)
        else $error("pins driven in chip reset");
    a_sensor_rst_low: assert property (
        !chip_reset_n [*4] |-> !sensor_reset_n_out && sensor_reset_oe)
        else $error("sensor reset not driven low");
    a_video_unused: assert property (
        !video_used |-> !frame_valid_oe)
        else $error("unused video pin driven");
    a_trig_unused: assert property (
        !trigger_used |-> !trigger_oe)
        else $error("unused trigger pin driven");
    a_trig_follow: assert property (
        $rose(frame_sync_in) |-> ##[1:4] trigger_out)
        else $error("trigger not copied");
    a_stby_entry: assert property (
        (standby_in && chip_reset_n && !sensor_frame_valid) [*4] |-> ##[0:3] sensor_reset_n_out)
        else $error("standby not entered");
    a_stby_exit: assert property (
        !standby_in [*6] |-> !sensor_reset_n_out)
        else $error("standby not left");
    a_softrst_len: assert property (
        $rose(soft_reset_active) |-> soft_reset_active [*8])
        else $error("soft reset too short");
    c_standby: cover property ($rose(sensor_reset_n_out));
    c_softrst: cover property ($rose(soft_reset_active));
    c_trigger: cover property ($rose(trigger_out) && trigger_oe);
endmodule : rssc_top_assertions

bind rssc_top rssc_top_assertions i_chk (.clk_sys, .rst, .chip_reset_n, .standby_in,
    .frame_sync_in, .sensor_frame_valid, .video_used, .trigger_used, .frame_valid_oe,
    .sensor_reset_n_out, .sensor_reset_oe, .trigger_out, .trigger_oe, .soft_reset_active);

// ### rssc_sensor_model.sv
// rssc_sensor_model.sv: image sensor behind the block, one frame per trigger edge, free running when continuous
// assumes: same clock as the block; 60-cycle frame, frame valid 40 of them
`timescale 1ns/100ps
module rssc_sensor_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        trigger,
    input  wire logic        continuous,
    output logic             frame_valid,
    output logic             line_valid,
    output logic      [11:0] pixel
);
    logic       trig_q;
    logic       run_q;
    logic [5:0] cnt_q;
    logic       last;
    assign last = cnt_q == 6'h3b;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            trig_q <= 1'b0;
            run_q  <= 1'b0;
            cnt_q  <= 6'h00;
        end else begin
            trig_q <= trigger;
            // free running only when told, else stop after one frame
            run_q  <= (trigger && !trig_q) || (run_q && !(last && !continuous));
            cnt_q  <= (run_q && !last) ? cnt_q + 6'h01 : 6'h00;
        end
    end
    assign frame_valid = run_q && cnt_q >= 6'h08 && cnt_q < 6'h30;
    assign line_valid  = frame_valid && !cnt_q[2];
    assign pixel       = line_valid ? {6'h2a, cnt_q} : ~{6'h2a, cnt_q};
endmodule : rssc_sensor_model

// ### rssc_top_tb.sv
// rssc_top_tb.sv: register-driven tests of reset, standby, frame sync and source select
// assumes: package, design, checker and sensor model compiled before it
`timescale 1ns/100ps
`include "rssc_cfg.svh"
module rssc_top_tb;
    logic clk_sys = 1'b0, rst = 1'b1, chip_reset_n = 1'b0, standby_in = 1'b0;
    logic frame_sync_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, model_cont = 1'b0;
    logic video_used = 1'b0, trigger_used = 1'b0, fv_q = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00, reg_rdata;
    logic reg_ack, strap_valid, frame_valid_out, frame_valid_oe, sensor_reset_n_out;
    logic sensor_frame_valid, sensor_line_valid, pipe_frame_valid, pipe_line_valid;
    logic sensor_reset_oe, trigger_out, trigger_oe, soft_reset_active;
    logic [11:0] sensor_pixel, pipe_pixel;
    logic [3:0] strap_out, strap_oe, strap_value;
    int fail_count = 0, num_checks = 0, cycles = 0, fv_rises = 0, n0, c0;
    rssc_top i_dut (.clk_sys, .rst, .chip_reset_n, .standby_in, .frame_sync_in, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_ack, .sensor_frame_valid,
        .sensor_line_valid, .sensor_pixel, .test_pixel(12'h5a5), .test_frame_valid(1'b1),
        .test_line_valid(1'b1), .video_used, .trigger_used, .strap_in(4'ha), .strap_out,
        .strap_oe, .strap_value, .strap_valid, .pipe_pixel, .pipe_frame_valid,
        .pipe_line_valid, .frame_valid_out, .frame_valid_oe, .sensor_reset_n_out,
        .sensor_reset_oe, .trigger_out, .trigger_oe, .soft_reset_active);
    // an undriven trigger pin reads as the inverse, so no hidden reliance on it
    rssc_sensor_model i_sensor (.clk_sys, .rst, .trigger(trigger_oe ? trigger_out : ~trigger_out),
        .continuous(model_cont), .frame_valid(sensor_frame_valid),
        .line_valid(sensor_line_valid), .pixel(sensor_pixel));
    always #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        fv_q <= frame_valid_out;
        if (frame_valid_out === 1'b1 && fv_q === 1'b0) fv_rises <= fv_rises + 1;
        // run takes about 1000 cycles
        if (cycles == 4000) begin
            fail_count++;
            finish_test();
        end
    end
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : chk
    // one-cycle strobe, answer looked for in the next three cycles
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic got, output logic [7:0] q);
        int n;
        @(posedge clk_sys);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        got = 1'b0;
        q = 8'h00;
        for (n = 0; n < 3 && !got; n++) begin
            #1;
            got = reg_ack === 1'b1;
            if (got) q = reg_rdata;
            if (!got) @(posedge clk_sys);
        end
    endtask : bus
    task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d,
                       input logic ack, input logic [7:0] q);
        logic       got;
        logic [7:0] r;
        bus(w, a, d, got, r);
        if (got && !w) chk(r === q, "read data");
        chk(got === ack, "acknowledge");
    endtask : acc
    // polls status without counting each poll as a check
    task automatic wait_state(input logic [7:0] st, input int lim);
        logic       got;
        logic [7:0] r;
        int         n;
        r = 8'h00;
        for (n = 0; n < lim && r !== st; n++) begin
            bus(1'b0, `RSSC_REG_STATUS, 8'h00, got, r);
        end
        chk(r === st, "state");
    endtask : wait_state
    task automatic sync_pulse;
        @(posedge clk_sys);
        frame_sync_in <= 1'b1;
        repeat (4) @(posedge clk_sys);
        frame_sync_in <= 1'b0;
    endtask : sync_pulse
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (14) @(posedge clk_sys);
        video_used <= 1'b1;
        trigger_used <= 1'b1;
        repeat (10) @(posedge clk_sys);
        #1;
        chk(frame_valid_oe === 1'b0 && trigger_oe === 1'b0, "pin driven");
        chk(sensor_reset_n_out === 1'b0 && sensor_reset_oe === 1'b1, "sensor reset");
        // chip reset held 60 cycles, clock running
        repeat (20) @(posedge clk_sys);
        chip_reset_n <= 1'b1;
        repeat (20) @(posedge clk_sys);
        acc(1'b1, `RSSC_REG_TRIG_MODE, 8'h01, 1'b0, 8'h00);
        repeat (100) @(posedge clk_sys);
        chk(strap_valid === 1'b1 && strap_value === 4'ha && strap_oe === 4'h0
            && strap_out === 4'h0, "strap");
        acc(1'b0, `RSSC_REG_STATUS, 8'h00, 1'b1, 8'h01);
        acc(1'b0, `RSSC_REG_TRIG_MODE, 8'h00, 1'b1, 8'h00);
        acc(1'b0, 16'h1234, 8'h00, 1'b1, 8'h00);
        acc(1'b0, `RSSC_REG_SRC_SEL, 8'h00, 1'b1, `RSSC_SRC_RESET);
        acc(1'b1, `RSSC_REG_SRC_SEL, `RSSC_SRC_TEST, 1'b1, 8'h00);
        acc(1'b0, `RSSC_REG_SRC_SEL, 8'h00, 1'b1, `RSSC_SRC_TEST);
        acc(1'b1, `RSSC_REG_CFG_APPLY, 8'h00, 1'b1, 8'h00);
        repeat (3) @(posedge clk_sys);
        #1;
        chk(pipe_pixel === 12'h5a5 && pipe_frame_valid === 1'b1
            && pipe_line_valid === 1'b1, "test pattern");
        acc(1'b1, `RSSC_REG_SRC_SEL, `RSSC_SRC_SENSOR, 1'b1, 8'h00);
        acc(1'b1, `RSSC_REG_CFG_APPLY, 8'h00, 1'b1, 8'h00);
        repeat (3) @(posedge clk_sys);
        #1;
        chk(pipe_pixel === sensor_pixel && pipe_frame_valid === 1'b0
            && pipe_line_valid === 1'b0, "sensor path");
        n0 = fv_rises;
        sync_pulse();
        wait_state(8'h02, 10);
        wait_state(8'h04, 40);
        repeat (100) @(posedge clk_sys);
        chk(fv_rises - n0 == 1, "single shot");
        model_cont <= 1'b1;
        acc(1'b1, `RSSC_REG_TRIG_MODE, 8'h01, 1'b1, 8'h00);
        n0 = fv_rises;
        sync_pulse();
        repeat (250) @(posedge clk_sys);
        chk(fv_rises - n0 >= 3, "continuous");
        // frame valid out trails the sensor by exactly one clock
        @(posedge sensor_frame_valid);
        #1;
        chk(frame_valid_out === 1'b0, "frame valid early");
        @(posedge clk_sys);
        #1;
        chk(frame_valid_out === 1'b1, "frame valid late");
        @(posedge clk_sys);
        standby_in <= 1'b1;
        c0 = cycles;
        wait_state(8'h08, 70);
        chk(cycles - c0 <= 128 && sensor_reset_n_out === 1'b1, "standby entry");
        // clock kept running before standby drops
        repeat (12) @(posedge clk_sys);
        standby_in <= 1'b0;
        wait_state(8'h04, 4);
        chk(sensor_reset_n_out === 1'b0, "standby exit");
        acc(1'b1, `RSSC_REG_SOFT_RST, 8'h01, 1'b1, 8'h00);
        chk(soft_reset_active === 1'b1, "soft reset");
        repeat (20) @(posedge clk_sys);
        wait_state(8'h01, 3);
        acc(1'b0, `RSSC_REG_TRIG_MODE, 8'h00, 1'b1, 8'h00);
        // chip reset in mid-run from standby
        standby_in <= 1'b1;
        wait_state(8'h08, 4);
        @(posedge clk_sys);
        chip_reset_n <= 1'b0;
        repeat (55) @(posedge clk_sys);
        #1;
        chk(trigger_oe === 1'b0 && frame_valid_oe === 1'b0
            && sensor_reset_n_out === 1'b0, "pins in reset");
        @(posedge clk_sys);
        standby_in <= 1'b0;
        chip_reset_n <= 1'b1;
        repeat (105) @(posedge clk_sys);
        acc(1'b0, `RSSC_REG_STATUS, 8'h00, 1'b1, 8'h01);
        finish_test();
    end
endmodule : rssc_top_tb
